// *** cmp_cache_mode.sv ***
// Cache policy control and prefetch queue self-modifying-code snoop.
`timescale 1ns/10ps

// Functional notes
// - Data write hitting a prefetched address flushes the prefetch queue.
// - Match uses linear addresses only; physical aliases are not detected.
// - Global flags 00B give writeback level-1 data and level-2 caches.
// - Range override registers override the type from the global flags.
// - Page cache-off and writethrough flags from base reg and entries apply.
// - Misc feature control bit 6 disables the level-3 cache.
// - Level-3 disable leaves level-1 and level-2 enables untouched.
// - Split level-1 instruction and data caches, unified level-2 cache.
// - Data cache defaults writeback, per-line writethrough selectable.
// - External hardware may force cache off or writethrough; honoured.
// - Per-page cache-off flag decides cacheability of each page.
module cmp_cache_mode #(
  parameter int LA_W  = 32,
  parameter int DEPTH = cmp_pkg::CMP_PFQ_DEPTH
) (
  input  wire logic            mclk_in,
  input  wire logic            rst_n_in,
  input  wire logic [3:0]      reg_addr_in,
  input  wire logic [31:0]     reg_wdata_in,
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  output logic      [31:0]     reg_rdata_out,
  input  wire logic            pf_push_in,
  input  wire logic [LA_W-1:0] pf_addr_in,
  input  wire logic            issue_req_in,
  output logic                 issue_ok_out,
  input  wire logic            dwr_valid_in,
  input  wire logic [LA_W-1:0] dwr_laddr_in,
  input  wire logic            serialize_in,
  input  wire logic            pde_pcd_in,
  input  wire logic            pde_pwt_in,
  input  wire logic            pte_pcd_in,
  input  wire logic            pte_pwt_in,
  input  wire logic            line_wt_in,
  input  wire logic            ext_cache_off_in,
  input  wire logic            ext_wt_in,
  output logic                 pf_flush_out,
  output logic [1:0]           d_policy_out,
  output logic                 l1i_en_out,
  output logic                 l1d_en_out,
  output logic                 l2_en_out,
  output logic                 l3_en_out
);

  logic [31:0]     ctrl0_q, ctrl0_d;
  logic [31:0]     pageb_q, pageb_d;
  logic [31:0]     misc_q, misc_d;
  logic [31:0]     range_q, range_d;
  logic [31:0]     rdata_q, rdata_d;
  logic [LA_W-1:0] pfq_addr_q [DEPTH];
  logic [DEPTH-1:0] pfq_vld_q, pfq_vld_d, hit_vec;
  logic [$clog2(DEPTH)-1:0] wptr_q, wptr_d;
  logic            flush_q, flush_d;
  logic            ext_off_s1_q, ext_off_s2_q, ext_wt_s1_q, ext_wt_s2_q;
  logic            snoop_hit, page_off, page_wt, glob_cd, glob_nw;
  logic            rng_en;
  logic [2:0]      rng_type;
  cmp_pkg::cmp_policy_type pol_d, pol_q;

  // External force pins arrive from outside the clock domain.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_off_s1_q <= 1'b0;
      ext_off_s2_q <= 1'b0;
      ext_wt_s1_q  <= 1'b0;
      ext_wt_s2_q  <= 1'b0;
    end else begin
      ext_off_s1_q <= ext_cache_off_in;
      ext_off_s2_q <= ext_off_s1_q;
      ext_wt_s1_q  <= ext_wt_in;
      ext_wt_s2_q  <= ext_wt_s1_q;
    end
  end

  // Register file writes and read data, answered one cycle after the strobe.
  always_comb begin
    ctrl0_d = ctrl0_q;
    pageb_d = pageb_q;
    misc_d  = misc_q;
    range_d = range_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        cmp_pkg::CMP_OFF_CTRL0: ctrl0_d = reg_wdata_in;
        cmp_pkg::CMP_OFF_PAGEB: pageb_d = reg_wdata_in;
        cmp_pkg::CMP_OFF_MISC:  misc_d  = reg_wdata_in;
        cmp_pkg::CMP_OFF_RANGE: range_d = {28'h000_0000, reg_wdata_in[3:0]};
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        cmp_pkg::CMP_OFF_CTRL0:  rdata_d = ctrl0_q;
        cmp_pkg::CMP_OFF_PAGEB:  rdata_d = pageb_q;
        cmp_pkg::CMP_OFF_MISC:   rdata_d = misc_q;
        cmp_pkg::CMP_OFF_RANGE:  rdata_d = range_q;
        cmp_pkg::CMP_OFF_STATUS: rdata_d = {24'h00_0000, l3_en_out,
                                   l2_en_out, l1d_en_out, l1i_en_out,
                                   flush_q, 1'b0, pol_q};
        default:                 rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register images and read data; reset leaves every cache disabled.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl0_q <= cmp_pkg::CMP_CTRL0_RST;
      pageb_q <= cmp_pkg::CMP_PAGEB_RST;
      misc_q  <= cmp_pkg::CMP_MISC_RST;
      range_q <= cmp_pkg::CMP_RANGE_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl0_q <= ctrl0_d;
      pageb_q <= pageb_d;
      misc_q  <= misc_d;
      range_q <= range_d;
      rdata_q <= rdata_d;
    end
  end

  // Read data leave straight from a flop and are zero outside a read.
  assign reg_rdata_out = rdata_q;

  // Cache enables: level-3 follows the global disable flag and its own disable flag.
  assign glob_cd    = ctrl0_q[cmp_pkg::CMP_CTRL0_CD_BIT];
  assign glob_nw    = ctrl0_q[cmp_pkg::CMP_CTRL0_NW_BIT];
  assign l1i_en_out = !glob_cd;
  assign l1d_en_out = !glob_cd;
  assign l2_en_out  = !glob_cd;
  assign l3_en_out  = !glob_cd && !misc_q[cmp_pkg::CMP_MISC_L3DIS_BIT];

  // Page flags combine base register, directory and table entries.
  assign page_off = pageb_q[cmp_pkg::CMP_PAGEB_PCD_BIT] | pde_pcd_in
                    | pte_pcd_in;
  assign page_wt  = pageb_q[cmp_pkg::CMP_PAGEB_PWT_BIT] | pde_pwt_in
                    | pte_pwt_in;
  assign rng_en   = range_q[cmp_pkg::CMP_RANGE_EN_BIT];
  assign rng_type = range_q[cmp_pkg::CMP_RANGE_TYPE_LSB +: 3];

  // Data policy: range override first, then global flags, then the
  // page, line and external forcing, each of which can only weaken it.
  always_comb begin
    pol_d = cmp_pkg::CMP_POL_WRITEBACK;
    if (rng_en) begin
      if (rng_type == cmp_pkg::CMP_MT_UC) begin
        pol_d = cmp_pkg::CMP_POL_UNCACHED;
      end else if (rng_type == cmp_pkg::CMP_MT_WT) begin
        pol_d = cmp_pkg::CMP_POL_WRITETHRU;
      end else begin
        pol_d = cmp_pkg::CMP_POL_WRITEBACK;
      end
    end else if (glob_cd) begin
      pol_d = cmp_pkg::CMP_POL_UNCACHED;
    end else if (glob_nw) begin
      pol_d = cmp_pkg::CMP_POL_WRITETHRU;
    end else begin
      pol_d = cmp_pkg::CMP_POL_WRITEBACK;
    end
    if (pol_d == cmp_pkg::CMP_POL_WRITEBACK && (page_wt || line_wt_in)) begin
      pol_d = cmp_pkg::CMP_POL_WRITETHRU;
    end
    if (pol_d == cmp_pkg::CMP_POL_WRITEBACK && ext_wt_s2_q) begin
      pol_d = cmp_pkg::CMP_POL_WRITETHRU;
    end
    if (page_off || ext_off_s2_q) begin
      pol_d = cmp_pkg::CMP_POL_UNCACHED;
    end
  end

  // Policy is registered so the output cannot glitch while flags settle.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pol_q <= cmp_pkg::CMP_POL_UNCACHED;
    end else begin
      pol_q <= pol_d;
    end
  end

  // The policy output comes straight from its flop.
  assign d_policy_out = pol_q;

  // Linear-address compare per prefetch entry; aliases are missed.
  for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
    assign hit_vec[i] = pfq_vld_q[i] && (pfq_addr_q[i] == dwr_laddr_in);
  end
  assign snoop_hit = dwr_valid_in && |hit_vec;

  // Queue state: a snoop hit or serialize empties the queue at once.
  always_comb begin
    pfq_vld_d = pfq_vld_q;
    wptr_d    = wptr_q;
    flush_d   = snoop_hit || serialize_in;
    if (flush_d) begin
      pfq_vld_d = '0;
      wptr_d    = '0;
    end else if (pf_push_in) begin
      pfq_vld_d[wptr_q] = 1'b1;
      wptr_d            = wptr_q + 1'b1;
    end
  end

  // Queue valid bits, write pointer and the one-cycle flush strobe.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pfq_vld_q <= '0;
      wptr_q    <= '0;
      flush_q   <= 1'b0;
    end else begin
      pfq_vld_q <= pfq_vld_d;
      wptr_q    <= wptr_d;
      flush_q   <= flush_d;
    end
  end

  // Address storage has no reset; the valid bits guard it.
  always_ff @(posedge mclk_in) begin
    if (pf_push_in && !flush_d) begin
      pfq_addr_q[wptr_q] <= pf_addr_in;
    end
  end

  // The flush strobe comes straight from its flop.
  assign pf_flush_out = flush_q;
  // Issue is held off in the hit cycle and the flush cycle after it.
  assign issue_ok_out = issue_req_in && !snoop_hit && !flush_q;

  // Checks on the snoop, the policy and the cache enables; each names the rule it guards.
  AST_HIT_FLUSH: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    snoop_hit |=> pf_flush_out && pfq_vld_q == '0)
    else $error("Snoop hit did not flush the prefetch queue.");
  AST_SER_FLUSH: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    serialize_in |=> pf_flush_out && pfq_vld_q == '0)
    else $error("Serializing operation did not flush the prefetch queue.");
  AST_NO_STALE: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    snoop_hit |-> !issue_ok_out ##1 !issue_ok_out)
    else $error("Instruction issued during a prefetch flush.");
  AST_LIN_ONLY: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (dwr_valid_in && !serialize_in && hit_vec == '0) |=> !pf_flush_out)
    else $error("Flush without a linear address match.");
  AST_WB_00: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (!rng_en && !glob_cd && !glob_nw && !page_off && !page_wt && !line_wt_in
     && !ext_off_s2_q && !ext_wt_s2_q)
    |=> d_policy_out == cmp_pkg::CMP_POL_WRITEBACK)
    else $error("Flags 00B did not give writeback.");
  AST_GLOB_CD: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (!rng_en && glob_cd) |=> d_policy_out == cmp_pkg::CMP_POL_UNCACHED)
    else $error("Global cache-disable ignored without a range override.");
  AST_RANGE_UC: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (rng_en && rng_type == cmp_pkg::CMP_MT_UC)
    |=> d_policy_out == cmp_pkg::CMP_POL_UNCACHED)
    else $error("Range override ignored.");
  AST_RANGE_WT: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (rng_en && rng_type == cmp_pkg::CMP_MT_WT && !page_off && !ext_off_s2_q)
    |=> d_policy_out == cmp_pkg::CMP_POL_WRITETHRU)
    else $error("Range writethrough override ignored.");
  AST_PAGE_OFF: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    page_off |=> d_policy_out == cmp_pkg::CMP_POL_UNCACHED)
    else $error("Page cache-off flag ignored.");
  AST_PAGE_WT: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (page_wt && !page_off && !ext_off_s2_q)
    |=> d_policy_out != cmp_pkg::CMP_POL_WRITEBACK)
    else $error("Page writethrough flag ignored.");
  AST_LINE_WT: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (line_wt_in && !page_off && !ext_off_s2_q)
    |=> d_policy_out != cmp_pkg::CMP_POL_WRITEBACK)
    else $error("Per-line writethrough ignored.");
  AST_EXT_OFF: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(ext_cache_off_in)
    |-> ##3 d_policy_out == cmp_pkg::CMP_POL_UNCACHED)
    else $error("External cache-off not honoured.");
  AST_EXT_WT: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(ext_wt_in)
    |-> ##3 d_policy_out != cmp_pkg::CMP_POL_WRITEBACK)
    else $error("External writethrough not honoured.");
  AST_L3_DIS: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    misc_q[cmp_pkg::CMP_MISC_L3DIS_BIT] |-> !l3_en_out)
    else $error("Level-3 cache enabled while disabled.");
  AST_L3_EN: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (!glob_cd && !misc_q[cmp_pkg::CMP_MISC_L3DIS_BIT]) |-> l3_en_out)
    else $error("Level-3 cache off although its flag is clear.");
  AST_L3_INDEP: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $changed(misc_q) && $stable(ctrl0_q) |-> $stable(l2_en_out)
    && $stable(l1d_en_out) && $stable(l1i_en_out))
    else $error("Level-3 disable changed lower-level enables.");
  AST_SPLIT_L1: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    l1d_en_out == l2_en_out && l1i_en_out == l2_en_out)
    else $error("Split level-1 enables diverged from level-2.");

endmodule // cmp_cache_mode

// *** cmp_pkg.sv ***
// Package of constants and types for the cache mode and prefetch snoop block.
package cmp_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] CMP_OFF_CTRL0  = 4'h0;
  localparam logic [3:0] CMP_OFF_PAGEB  = 4'h1;
  localparam logic [3:0] CMP_OFF_MISC   = 4'h2;
  localparam logic [3:0] CMP_OFF_RANGE  = 4'h3;
  localparam logic [3:0] CMP_OFF_STATUS = 4'h4;

  // Field positions in the control register zero image.
  localparam int CMP_CTRL0_CD_BIT = 30;
  localparam int CMP_CTRL0_NW_BIT = 29;
  // Field positions in the page-base control register image.
  localparam int CMP_PAGEB_PWT_BIT = 3;
  localparam int CMP_PAGEB_PCD_BIT = 4;
  // Level-3 disable flag in the miscellaneous feature control register.
  localparam int CMP_MISC_L3DIS_BIT = 6;
  // Range override register: bit 0 enable, bits 3:1 memory type code.
  localparam int CMP_RANGE_EN_BIT = 0;
  localparam int CMP_RANGE_TYPE_LSB = 1;

  // Reset values: caching disabled, as after a processor reset.
  localparam logic [31:0] CMP_CTRL0_RST = 32'h6000_0000;
  localparam logic [31:0] CMP_PAGEB_RST = 32'h0000_0000;
  localparam logic [31:0] CMP_MISC_RST  = 32'h0000_0000;
  localparam logic [31:0] CMP_RANGE_RST = 32'h0000_0000;

  // Memory type codes used by the range override.
  localparam logic [2:0] CMP_MT_UC = 3'h0;
  localparam logic [2:0] CMP_MT_WT = 3'h4;
  localparam logic [2:0] CMP_MT_WB = 3'h6;

  // Effective per-access cache policy.
  typedef enum logic [1:0] {
    CMP_POL_UNCACHED,
    CMP_POL_WRITETHRU,
    CMP_POL_WRITEBACK
  } cmp_policy_type;

  // Prefetch queue depth.
  localparam int CMP_PFQ_DEPTH = 4;

endpackage

// *** tb.sv ***
// Self-checking testbench for the cache mode and prefetch snoop block.
`timescale 1ns/10ps
module tb;
  logic        mclk_in;
  logic        rst_n_in;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        pf_push;
  logic [31:0] pf_addr;
  logic        issue_req;
  logic        issue_ok;
  logic        dwr_valid;
  logic [31:0] dwr_laddr;
  logic        serialize;
  logic [6:0]  fl;
  logic        pf_flush;
  logic [1:0]  d_policy;
  logic [3:0]  en;
  logic [31:0] rv;
  int          errors;
  int          samples_checked;
  int          seed;
  int          c0;
  int          pb;
  int          mi;
  int          rg;
  int          e;

  cmp_cache_mode u_cmp_cache_mode (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .pf_push_in(pf_push), .pf_addr_in(pf_addr),
    .issue_req_in(issue_req), .issue_ok_out(issue_ok),
    .dwr_valid_in(dwr_valid), .dwr_laddr_in(dwr_laddr),
    .serialize_in(serialize), .pde_pcd_in(fl[0]), .pde_pwt_in(fl[1]),
    .pte_pcd_in(fl[2]), .pte_pwt_in(fl[3]), .line_wt_in(fl[4]),
    .ext_cache_off_in(fl[5]), .ext_wt_in(fl[6]), .pf_flush_out(pf_flush),
    .d_policy_out(d_policy), .l1i_en_out(en[0]), .l1d_en_out(en[1]),
    .l2_en_out(en[2]), .l3_en_out(en[3]));

  // Free-running core clock, 4 ns period.
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  // Comparison counted in every case; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Policy model: range override wins over the global flags, then page,
  // line and external write-through downgrade, and cache-off forces uncached.
  function automatic int exp_pol(int c0, int pb, int rg, int f);
    int p;
    int t;
    t = (rg >> 1) & 7;
    if (rg & 1) p = (t == 0) ? 0 : ((t == 4) ? 1 : 2);
    else if ((c0 >> 30) & 1) p = 0;
    else p = ((c0 >> 29) & 1) ? 1 : 2;
    if (p == 2 && (((pb >> 3) & 1) || (f & 8'h5A))) p = 1;
    if (((pb >> 4) & 1) || (f & 8'h25)) p = 0;
    return p;
  endfunction

  task automatic end_of_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog sized well beyond the length of the whole sequence.
  initial begin
    repeat (20000) @(posedge mclk_in);
    errors++;
    end_of_test;
  end

  // Main sequence: reset, register map, random policy sweep, snoop flushes.
  initial begin
    errors = 0; samples_checked = 0; seed = 96;
    rst_n_in = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0; reg_wr = 1'b0;
    reg_rd = 1'b0; pf_push = 1'b0; pf_addr = 32'h0; issue_req = 1'b0;
    dwr_valid = 1'b0; dwr_laddr = 32'h0; serialize = 1'b0; fl = 7'h00;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(cmp_pkg::CMP_OFF_CTRL0, rv); chk(rv, 32'h6000_0000);
    chk({28'h0, en}, 32'h0);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, rv); chk(rv, 32'h0);
    wr(cmp_pkg::CMP_OFF_CTRL0, 32'h0);
    repeat (5) @(posedge mclk_in);
    #1 chk({30'h0, d_policy}, 32'h2);
    chk({28'h0, en}, 32'hF);
    for (int i = 0; i < 60; i++) begin
      c0 = $random(seed) & 32'h6000_0000;
      pb = $random(seed) & 32'h18;
      mi = $random(seed) & 32'h40;
      rg = $random(seed) & 32'hF;
      wr(cmp_pkg::CMP_OFF_CTRL0, c0);
      wr(cmp_pkg::CMP_OFF_PAGEB, pb);
      wr(cmp_pkg::CMP_OFF_MISC, mi);
      wr(cmp_pkg::CMP_OFF_RANGE, rg);
      fl <= 7'($random(seed) & $random(seed));
      repeat (5) @(posedge mclk_in);
      #1 e = exp_pol(c0, pb, rg, int'(fl));
      chk({30'h0, d_policy}, e);
      chk({28'h0, en}, ((c0 >> 30) & 1) ? 0 : ((mi != 0) ? 7 : 15));
      rd(cmp_pkg::CMP_OFF_MISC, rv); chk(rv, mi);
      rd(cmp_pkg::CMP_OFF_RANGE, rv); chk(rv, rg);
      rd(cmp_pkg::CMP_OFF_STATUS, rv);
      chk(rv & 32'hF3, {24'h0, en, 2'h0, e[1:0]});
    end
    fl <= 7'h00;
    wr(cmp_pkg::CMP_OFF_RANGE, 32'h0);
    issue_req <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk_in);
      pf_push <= 1'b1; pf_addr <= 32'h0000_1000 + k;
      @(posedge mclk_in);
      pf_push <= 1'b0;
      dwr_valid <= (k != 2); serialize <= (k == 2);
      dwr_laddr <= (k == 1) ? 32'h8000_1001 : 32'h0000_1000;
      #1 chk({31'h0, issue_ok}, (k == 0) ? 0 : 1);
      @(posedge mclk_in);
      dwr_valid <= 1'b0; serialize <= 1'b0;
      #1 chk({31'h0, pf_flush}, (k == 1) ? 0 : 1);
      chk({31'h0, issue_ok}, (k == 1) ? 1 : 0);
      @(posedge mclk_in);
      #1 chk({31'h0, pf_flush}, 32'h0);
    end
    end_of_test;
  end
endmodule // tb
